// ---- bpsp_pkg.sv ----
// Shared constants, types and helpers for the backplane stream port.
// Assumes a 125 MHz reference clock and an 8.192 MHz master clock pin.
package bpsp_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS  = 8;
	localparam int unsigned MCLK_PERIOD_PS = 122070;
	localparam int unsigned FP_SHORT_NS    = 122;
	localparam int unsigned FP_LONG_NS     = 244;
	localparam int unsigned FRAME_NS       = 125000;
	// Quarter master-clock period in reference cycles, rounded down, at least one
	localparam int unsigned QTICK_RAW      = (MCLK_PERIOD_PS / 4) / (CLK_PERIOD_NS * 1000);
	localparam logic [4:0]  QTICK_CYC      = 5'((QTICK_RAW < 1) ? 1 : QTICK_RAW);
	// Frame pulse widths as counts of master clock edges
	localparam logic [1:0]  FP_SHORT_EDGES = 2'((FP_SHORT_NS * 1000 + MCLK_PERIOD_PS / 2) / MCLK_PERIOD_PS);
	localparam logic [1:0]  FP_LONG_EDGES  = 2'((FP_LONG_NS * 1000 + MCLK_PERIOD_PS / 2) / MCLK_PERIOD_PS);
	localparam int unsigned FRAME_CYC      = (FRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Frame geometry
	localparam logic [10:0] MCLK_EDGES_PER_FRAME = 11'h400;
	localparam logic [10:0] MCLK_EDGES_HALF      = 11'h200;
	localparam logic [11:0] POS_RESET            = 12'h000;
	localparam logic [8:0]  CHAN_LIMIT_NARROW    = 9'h100;
	localparam int unsigned STREAMS              = 32;
	localparam int unsigned HALF_STREAMS         = 16;
	localparam logic [31:0] GROUP0_MASK          = 32'h1111_1111;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		RATE_2M  = 2'h0,
		RATE_4M  = 2'h1,
		RATE_8M  = 2'h2,
		RATE_16M = 2'h3
	} bpsp_rate_e;

	typedef enum logic [2:0] {
		ST_DETECT = 3'b001,
		ST_ALIGN  = 3'b010,
		ST_RUN    = 3'b100
	} bpsp_state_e;

	typedef struct packed {
		logic mode32;
		logic pulse_width_select;
		logic clock_polarity_select;
		logic bp_output_reset_state;
		logic output_drive_enable;
	} bpsp_cfg_s;

	typedef struct packed {
		logic        tick;
		logic [11:0] pos;
		logic        frame_start;
		logic        locked;
		logic        gci;
	} bpsp_time_s;

	// ==========================================================
	// Helpers
	// Quarter-ticks per bit, as a shift: 32M=0 .. 2M=4
	function automatic logic [2:0] rate_shift(input logic mode32, input logic [1:0] code);
		rate_shift = mode32 ? 3'h0 : 3'(3'h4 - {1'b0, code});
	endfunction

	function automatic logic bit_step(input logic [11:0] pos, input logic [2:0] sh);
		logic [11:0] mask;
		mask     = 12'((12'h1 << sh) - 12'h1);
		bit_step = ((pos & mask) == 12'h000);
	endfunction

	function automatic logic [11:0] bit_index(input logic [11:0] pos, input logic [2:0] sh);
		bit_index = pos >> sh;
	endfunction

endpackage

// ---- bpsp_frame_timer.sv ----
// Master clock and frame pulse recovery, format detection, frame position.
// Assumes both inputs are raw pins, asynchronous to the reference clock.
`timescale 1ns/1ns
module bpsp_frame_timer import bpsp_pkg::*; (
	// Clock and reset
	input  wire logic  ref_clk_i,
	input  wire logic  rst_i,
	// Pins and setup
	input  wire logic  master_clock_in_i,
	input  wire logic  frame_pulse_in_i,
	input  wire logic  pulse_width_select_i,
	// Frame timing
	output bpsp_time_s time_o
);
	logic [2:0]  mclk_sync_reg;
	logic [2:0]  fp_sync_reg;
	logic        mclk_lvl_reg;
	logic        fp_lvl_reg;
	logic        gci_reg;
	logic [1:0]  run_reg;
	logic [10:0] edge_reg;
	logic [10:0] low_reg;
	logic [4:0]  phase_reg;
	bpsp_state_e state_reg;
	bpsp_time_s  time_reg;
	logic        mclk_rise;
	logic        fp_active;
	logic [1:0]  fp_width;
	logic        boundary;
	logic        tick_go;

	// ==========================================================
	// Pin synchronisers, a change counts when stages two and three agree
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			mclk_sync_reg <= 3'h0;
			fp_sync_reg   <= 3'h7;
		end else begin
			mclk_sync_reg <= {mclk_sync_reg[1:0], master_clock_in_i};
			fp_sync_reg   <= {fp_sync_reg[1:0], frame_pulse_in_i};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			mclk_lvl_reg <= 1'b0;
			fp_lvl_reg   <= 1'b1;
		end else begin
			if (mclk_sync_reg[1] == mclk_sync_reg[2])
				mclk_lvl_reg <= mclk_sync_reg[2];
			if (fp_sync_reg[1] == fp_sync_reg[2])
				fp_lvl_reg <= fp_sync_reg[2];
		end
	end

	// Only the rising master clock edge marks time
	assign mclk_rise = (mclk_sync_reg[1] == mclk_sync_reg[2]) && mclk_sync_reg[2] && !mclk_lvl_reg;
	// Low-active pulse for the one style, high-active for the other
	assign fp_active = gci_reg ? fp_lvl_reg : !fp_lvl_reg;
	assign fp_width  = pulse_width_select_i ? FP_LONG_EDGES : FP_SHORT_EDGES;
	assign boundary  = mclk_rise && fp_active && (2'(run_reg + 2'h1) == fp_width);
	assign tick_go   = (state_reg == ST_RUN) || ((state_reg == ST_ALIGN) && boundary);

	// ==========================================================
	// Pulse run length, counted in master clock edges
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			run_reg <= 2'h0;
		else if (mclk_rise)
			run_reg <= fp_active ? ((run_reg == 2'h3) ? run_reg : 2'(run_reg + 2'h1)) : 2'h0;
	end

	// ==========================================================
	// Two-frame start-up: one frame to learn the pulse style, one to align
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_reg <= ST_DETECT;
			edge_reg  <= 11'h000;
			low_reg   <= 11'h000;
			gci_reg   <= 1'b0;
		end else begin
			case (state_reg)
				ST_DETECT: begin
					if (mclk_rise) begin
						edge_reg <= 11'(edge_reg + 11'h001);
						low_reg  <= 11'(low_reg + {10'h000, !fp_lvl_reg});
						if (11'(edge_reg + 11'h001) == MCLK_EDGES_PER_FRAME) begin
							// Pulse is the short minority level of the frame
							gci_reg   <= (low_reg >= MCLK_EDGES_HALF);
							state_reg <= ST_ALIGN;
						end
					end
				end
				ST_ALIGN:
					if (boundary)
						state_reg <= ST_RUN;
				ST_RUN:
					state_reg <= ST_RUN;
				default:
					state_reg <= ST_DETECT;
			endcase
		end
	end

	// ==========================================================
	// Quarter-period phase: four ticks per master clock period
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			phase_reg <= 5'h00;
		else if (mclk_rise)
			phase_reg <= 5'h01;
		else if (phase_reg != 5'h1f)
			phase_reg <= 5'(phase_reg + 5'h01);
	end

	// ==========================================================
	// Frame position in quarter ticks, zeroed at each boundary
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			time_reg <= '0;
		end else begin
			time_reg.tick        <= tick_go && (mclk_rise || phase_reg == QTICK_CYC ||
				phase_reg == 5'(2 * QTICK_CYC) || phase_reg == 5'(3 * QTICK_CYC));
			time_reg.frame_start <= tick_go && boundary;
			time_reg.locked      <= (state_reg == ST_RUN);
			time_reg.gci         <= gci_reg;
			if (tick_go && boundary)
				time_reg.pos <= POS_RESET;
			else if (tick_go && (mclk_rise || phase_reg == QTICK_CYC ||
				phase_reg == 5'(2 * QTICK_CYC) || phase_reg == 5'(3 * QTICK_CYC)))
				time_reg.pos <= 12'(time_reg.pos + 12'h001);
		end
	end

	assign time_o = time_reg;

endmodule

// ---- bpsp_lane.sv ----
// One backplane stream: input deserialiser and output serialiser.
// Assumes the serial input is already synchronised to the reference clock.
`timescale 1ns/1ns
module bpsp_lane import bpsp_pkg::*; (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	// Frame timing
	input  wire logic       tick_i,
	input  wire logic [11:0] pos_i,
	input  wire logic [2:0] in_shift_i,
	input  wire logic [2:0] out_shift_i,
	// Receive side
	input  wire logic       serial_in_i,
	output logic      [7:0] rx_data_o,
	output logic      [8:0] rx_chan_o,
	output logic            rx_valid_o,
	// Transmit side
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_active_i,
	output logic      [8:0] tx_chan_o,
	output logic            serial_out_o,
	output logic            tx_en_o
);
	logic [7:0]  in_sh_reg;
	logic [7:0]  out_sh_reg;
	logic        tx_en_reg;
	logic [11:0] in_bit;
	logic [11:0] out_bit;
	logic        in_step;
	logic        out_step;

	assign in_bit   = bit_index(pos_i, in_shift_i);
	assign out_bit  = bit_index(pos_i, out_shift_i);
	assign in_step  = tick_i && bit_step(pos_i, in_shift_i);
	assign out_step = tick_i && bit_step(pos_i, out_shift_i);

	// ==========================================================
	// Receive: MSB first, a byte handed out after its eighth bit
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			in_sh_reg  <= 8'h00;
			rx_data_o  <= 8'h00;
			rx_chan_o  <= 9'h000;
			rx_valid_o <= 1'b0;
		end else begin
			rx_valid_o <= 1'b0;
			if (in_step) begin
				in_sh_reg <= {in_sh_reg[6:0], serial_in_i};
				if (in_bit[2:0] == 3'h7) begin
					rx_data_o  <= {in_sh_reg[6:0], serial_in_i};
					rx_chan_o  <= in_bit[11:3];
					rx_valid_o <= 1'b1;
				end
			end
		end
	end

	// Channel being fetched; the byte is taken on its first bit
	assign tx_chan_o = out_bit[11:3];

	// ==========================================================
	// Transmit: load at bit zero, idle line is high
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			out_sh_reg <= 8'hff;
			tx_en_reg  <= 1'b0;
		end else if (out_step) begin
			if (out_bit[2:0] == 3'h0) begin
				out_sh_reg <= tx_data_i;
				tx_en_reg  <= tx_active_i;
			end else begin
				out_sh_reg <= {out_sh_reg[6:0], 1'b1};
			end
		end
	end

	assign serial_out_o = out_sh_reg[7];
	assign tx_en_o      = tx_en_reg;

endmodule

// ---- bpsp_port.sv ----
// Backplane serial TDM stream port: 32 in / 32 out streams, or 16 at 32 Mb/s.
// Assumes a 125 MHz reference clock; all frame timing pins are asynchronous.
//
// What this block does
// - Input rates 16/8/4/2 Mb/s, 256..32 channels
// - Each input stream rate set independently
// - Each output stream rate set independently
// - 32 Mb/s mode: streams 0-15, 512 channels
// - 32 Mb/s mode ignores inputs 16 to 31
// - 32 Mb/s mode leaves outputs 16-31 unused
// - Enable k covers streams with index mod 4
// - 32 Mb/s: enable 3 covers 3,7,11,15
// - Frame pulse 122 or 244 ns, width select
// - Auto-detect frame pulse style
// - Frame boundary on master clock rising edge
// - Reset asserts asynchronously, releases synchronously
// - In reset outputs high or high-impedance
// - Reset clears registers and counters
// - Initial output state follows reset state input
// - Drive enable low forces idle outputs
// - Two frames of start-up first: format detection, then alignment
`timescale 1ns/1ns
module bpsp_port import bpsp_pkg::*; #(
	parameter int unsigned FRAME_CYCLES = FRAME_CYC
) (
	// Clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             reset_i,
	input  wire logic             device_reset_n_i,
	// Frame timing pins
	input  wire logic             master_clock_in_i,
	input  wire logic             frame_pulse_in_i,
	// Configuration
	input  wire bpsp_cfg_s        cfg_i,
	input  wire logic [31:0][1:0] in_rate_i,
	input  wire logic [31:0][1:0] out_rate_i,
	// Serial inputs
	input  wire logic [15:0]      bp_serial_in_low_i,
	input  wire logic [15:0]      bp_serial_in_high_i,
	// Serial outputs, oe_n enables low while driving, buffer enables high
	output logic      [15:0]      bp_serial_out_low_o,
	output logic      [15:0]      bp_serial_out_low_oe_n_o,
	output logic      [15:0]      bp_serial_out_high_o,
	output logic      [15:0]      bp_serial_out_high_oe_n_o,
	output logic      [3:0]       bp_channel_buffer_enable_o,
	// Channel data to send
	input  wire logic [31:0][7:0] tx_data_i,
	input  wire logic [31:0]      bp_channel_active_bit_i,
	output logic      [31:0][8:0] tx_chan_o,
	// Channel data received
	output logic      [31:0][7:0] rx_data_o,
	output logic      [31:0][8:0] rx_chan_o,
	output logic      [31:0]      rx_valid_o,
	// Status
	output logic                  frame_locked_o,
	output logic                  gci_format_o,
	output logic                  frame_start_o
);
	logic [2:0]  rstn_sync_reg;
	logic        rstn_lvl_reg;
	logic        int_rst;
	logic [31:0] din_s0_reg;
	logic [31:0] din_s1_reg;
	logic [31:0] din_s2_reg;
	logic [31:0] din_lvl_reg;
	logic [31:0] din_agree;
	logic [31:0] lane_live;
	logic [31:0] lane_out;
	logic [31:0] lane_en;
	logic [31:0] pin_out;
	logic [31:0] pin_oe_n;
	logic [3:0]  be_reg;
	logic        force_idle;
	bpsp_time_s  tm;

	// ==========================================================
	// Device reset pin: synchronised release, internal reset held meanwhile
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			rstn_sync_reg <= 3'h0;
		else
			rstn_sync_reg <= {rstn_sync_reg[1:0], device_reset_n_i};
	end

	// A pulse shorter than the synchroniser agreement window is not seen
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			rstn_lvl_reg <= 1'b0;
		else if (rstn_sync_reg[1] == rstn_sync_reg[2])
			rstn_lvl_reg <= rstn_sync_reg[2];
	end

	assign int_rst = reset_i || !rstn_lvl_reg;

	// ==========================================================
	// Serial input synchronisers, three stages per pin
	always_ff @(posedge ref_clk_i) begin
		if (int_rst) begin
			din_s0_reg <= 32'h0000_0000;
			din_s1_reg <= 32'h0000_0000;
			din_s2_reg <= 32'h0000_0000;
		end else begin
			din_s0_reg <= {bp_serial_in_high_i, bp_serial_in_low_i};
			din_s1_reg <= din_s0_reg;
			din_s2_reg <= din_s1_reg;
		end
	end

	assign din_agree = ~(din_s1_reg ^ din_s2_reg);

	always_ff @(posedge ref_clk_i) begin
		if (int_rst)
			din_lvl_reg <= 32'h0000_0000;
		else
			din_lvl_reg <= (din_s2_reg & din_agree) | (din_lvl_reg & ~din_agree);
	end

	// ==========================================================
	// Frame recovery; clock_polarity_select is expected at one, only rising edges align
	bpsp_frame_timer u_timer (
		.ref_clk_i            (ref_clk_i),
		.rst_i                (int_rst),
		.master_clock_in_i    (master_clock_in_i),
		.frame_pulse_in_i     (frame_pulse_in_i),
		.pulse_width_select_i (cfg_i.pulse_width_select),
		.time_o               (tm)
	);

	// ==========================================================
	// Stream lanes; upper half sits idle in the 32 Mb/s mode
	for (genvar s = 0; s < STREAMS; s++) begin : g_lane
		assign lane_live[s] = !cfg_i.mode32 || (s < HALF_STREAMS);

		bpsp_lane u_lane (
			.ref_clk_i    (ref_clk_i),
			.rst_i        (int_rst),
			.tick_i       (tm.tick && lane_live[s]),
			.pos_i        (tm.pos),
			.in_shift_i   (rate_shift(cfg_i.mode32, in_rate_i[s])),
			.out_shift_i  (rate_shift(cfg_i.mode32, out_rate_i[s])),
			.serial_in_i  (din_lvl_reg[s]),
			.rx_data_o    (rx_data_o[s]),
			.rx_chan_o    (rx_chan_o[s]),
			.rx_valid_o   (rx_valid_o[s]),
			.tx_data_i    (tx_data_i[s]),
			.tx_active_i  (bp_channel_active_bit_i[s]),
			.tx_chan_o    (tx_chan_o[s]),
			.serial_out_o (lane_out[s]),
			.tx_en_o      (lane_en[s])
		);
	end

	// ==========================================================
	// Buffer enables: group k is every live stream with index mod 4 == k
	always_ff @(posedge ref_clk_i) begin
		if (int_rst)
			be_reg <= 4'h0;
		else
			for (int k = 0; k < 4; k++)
				be_reg[k] <= |(lane_en & lane_live & (GROUP0_MASK << k));
	end

	// ==========================================================
	// Output forcing; the reset pin acts here without waiting for a clock
	assign force_idle = !device_reset_n_i || int_rst || !cfg_i.output_drive_enable || !tm.locked;

	always_comb begin
		for (int s = 0; s < STREAMS; s++) begin
			if (force_idle || !lane_live[s]) begin
				pin_out[s]  = 1'b1;
				pin_oe_n[s] = cfg_i.bp_output_reset_state;
			end else begin
				pin_out[s]  = lane_out[s];
				// Tristate per channel only when the reset state asks for it
				pin_oe_n[s] = cfg_i.bp_output_reset_state && !lane_en[s];
			end
		end
	end

	assign bp_serial_out_low_o        = pin_out[15:0];
	assign bp_serial_out_high_o       = pin_out[31:16];
	assign bp_serial_out_low_oe_n_o   = pin_oe_n[15:0];
	assign bp_serial_out_high_oe_n_o  = pin_oe_n[31:16];
	assign bp_channel_buffer_enable_o = force_idle ? 4'h0 : be_reg;
	assign frame_locked_o             = tm.locked;
	assign gci_format_o               = tm.gci;
	assign frame_start_o              = tm.frame_start;

	// ==========================================================
	// Checks
	logic [14:0] since_rst_reg;

	// Cycles since reset, saturating
	always_ff @(posedge ref_clk_i) begin
		if (int_rst)
			since_rst_reg <= 15'h0000;
		else if (since_rst_reg != 15'h7fff)
			since_rst_reg <= 15'(since_rst_reg + 15'h0001);
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (int_rst);

	drive_idle_a: assert property (!cfg_i.output_drive_enable |->
		(&pin_out) && pin_oe_n == {32{cfg_i.bp_output_reset_state}} &&
		bp_channel_buffer_enable_o == 4'h0) else $error("drive enable low left outputs active");
	hiz_state_a: assert property (!cfg_i.output_drive_enable && cfg_i.bp_output_reset_state |->
		(&pin_oe_n)) else $error("outputs not high-impedance while forced");
	driven_state_a: assert property (!tm.locked && !cfg_i.bp_output_reset_state |->
		(pin_oe_n == 32'h0) && (&pin_out)) else $error("outputs not driven high before lock");
	upper_unused_a: assert property (cfg_i.mode32 |-> (&pin_out[31:16]) &&
		pin_oe_n[31:16] == {16{cfg_i.bp_output_reset_state}}) else $error("upper stream used in fast mode");
	lock_delay_a: assert property ($rose(tm.locked) |-> since_rst_reg >= 15'(FRAME_CYCLES))
		else $error("lock before a full detection frame");
	fast_chan_a: assert property (cfg_i.mode32 && tm.tick |-> tx_chan_o[0] == tm.pos[11:3])
		else $error("fast mode channel count wrong");
	narrow_chan_a: assert property (!cfg_i.mode32 |-> tx_chan_o[1] < CHAN_LIMIT_NARROW)
		else $error("narrow mode channel beyond 255");
	group_enable_a: assert property ($rose(be_reg[3]) |-> $past(|(lane_en & lane_live &
		(GROUP0_MASK << 3)))) else $error("buffer enable without active member");
	frame_zero_a: assert property (tm.frame_start |-> tm.pos == POS_RESET ##1 tm.locked)
		else $error("boundary not at position zero");
	rst_clear_a: assert property (@(posedge ref_clk_i) disable iff (1'b0) $past(int_rst) |->
		(tm.pos == POS_RESET) && !tm.locked && be_reg == 4'h0) else $error("reset left state");

	// Reset pin, fast-mode inputs and enable grouping
	pin_reset_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) !device_reset_n_i |->
		(&pin_out) && bp_channel_buffer_enable_o == 4'h0) else $error("reset pin left outputs active");
	upper_quiet_a: assert property (cfg_i.mode32 && $past(cfg_i.mode32) |->
		rx_valid_o[31:16] == 16'h0000) else $error("upper input received in fast mode");
	group_zero_a: assert property ($rose(be_reg[0]) |-> $past(|(lane_en & lane_live &
		GROUP0_MASK))) else $error("buffer enable 0 without active member");
	enable_idle_a: assert property ((lane_en & lane_live) == 32'h0 |=> be_reg == 4'h0)
		else $error("buffer enable with no active channel");

	lock_seen_c: cover property ($rose(tm.locked));
	gci_seen_c:  cover property (tm.locked && tm.gci);
	fast_rx_c:   cover property (cfg_i.mode32 && rx_valid_o[15]);
	enable3_c:   cover property (bp_channel_buffer_enable_o[3]);
	drive_off_c: cover property (tm.locked && !cfg_i.output_drive_enable);

endmodule

// ---- bpsp_far_model.sv ----
// Far side of the backplane: master clock, frame pulse, serial input data.
// Assumes the port samples all of these pins asynchronously.
`timescale 1ns/1ns
module bpsp_far_model (
	// Timing pins
	output logic        master_clock_o,
	output logic        frame_pulse_o,
	// Serial data towards the port
	output logic [15:0] serial_low_o,
	output logic [15:0] serial_high_o
);
	logic [9:0] rise_cnt;

	// ==========================================================
	// Clock and frame pulse
	// 122 ns clock; low-active pulse spans only rise 0 of 1024
	initial begin
		master_clock_o = 1'b0;
		frame_pulse_o  = 1'b1;
		rise_cnt       = 10'h000;
		forever begin
			#61 master_clock_o = 1'b1;
			rise_cnt = rise_cnt + 10'h001;
			#61 master_clock_o = 1'b0;
			frame_pulse_o = (rise_cnt != 10'h3ff);
		end
	end

	// Constant lines, so a bit slip cannot alter received bytes
	assign serial_low_o  = 16'h5555;
	assign serial_high_o = 16'haaaa;
endmodule

// ---- bpsp_port_tb_top.sv ----
// Self-checking bench for the backplane stream port.
// Assumes the far model gives ST style timing and constant input lines.
`timescale 1ns/1ns
module bpsp_port_tb_top;
	import bpsp_pkg::*;
	logic             ref_clk_i;
	logic             reset_i;
	logic             device_reset_n_i;
	logic             master_clock_in_i;
	logic             frame_pulse_in_i;
	bpsp_cfg_s        cfg_i;
	logic [31:0][1:0] in_rate_i;
	logic [31:0][1:0] out_rate_i;
	logic [15:0]      bp_serial_in_low_i;
	logic [15:0]      bp_serial_in_high_i;
	logic [15:0]      bp_serial_out_low_o;
	logic [15:0]      bp_serial_out_low_oe_n_o;
	logic [15:0]      bp_serial_out_high_o;
	logic [15:0]      bp_serial_out_high_oe_n_o;
	logic [3:0]       bp_channel_buffer_enable_o;
	logic [31:0][7:0] tx_data_i;
	logic [31:0]      bp_channel_active_bit_i;
	logic [31:0][8:0] tx_chan_o;
	logic [31:0][7:0] rx_data_o;
	logic [31:0][8:0] rx_chan_o;
	logic [31:0]      rx_valid_o;
	logic             frame_locked_o;
	logic             gci_format_o;
	logic             frame_start_o;
	int               n_mismatch;
	int               compares;
	int               cycles;
	int               cnt[32];
	logic [8:0]       maxch[32];
	logic [3:0]       bce_or;
	logic [15:0]      hi_and;
	logic [15:0]      lo_and;

	bpsp_port i_dut (.ref_clk_i, .reset_i, .device_reset_n_i, .master_clock_in_i, .frame_pulse_in_i,
		.cfg_i, .in_rate_i, .out_rate_i, .bp_serial_in_low_i, .bp_serial_in_high_i, .bp_serial_out_low_o,
		.bp_serial_out_low_oe_n_o, .bp_serial_out_high_o, .bp_serial_out_high_oe_n_o,
		.bp_channel_buffer_enable_o, .tx_data_i, .bp_channel_active_bit_i, .tx_chan_o, .rx_data_o,
		.rx_chan_o, .rx_valid_o, .frame_locked_o, .gci_format_o, .frame_start_o);

	bpsp_far_model i_far (.master_clock_o(master_clock_in_i), .frame_pulse_o(frame_pulse_in_i),
		.serial_low_o(bp_serial_in_low_i), .serial_high_o(bp_serial_in_high_i));

	// ==========================================================
	// Clock and hang guard, sized for about six frames
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			n_mismatch++;
			conclude();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// One whole frame between two boundary pulses; bytes on every stream judged
	task automatic measure();
		int s;
		while (frame_start_o !== 1'b1) @(negedge ref_clk_i);
		for (s = 0; s < 32; s++) begin
			cnt[s] = 0;
			maxch[s] = 9'h000;
		end
		bce_or = 4'h0;
		hi_and = 16'hffff;
		lo_and = 16'hffff;
		do begin
			@(negedge ref_clk_i);
			for (s = 0; s < 32; s++) begin
				if (rx_valid_o[s] === 1'b1) begin
					cnt[s]++;
					check("rx byte", 32'(rx_data_o[s]), (32'haaaa_5555 >> s) & 1 ? 32'hff : 32'h0);
					check("rx chan", 32'(rx_chan_o[s]), 32'(cnt[s] - 1));
				end
				if (tx_chan_o[s] > maxch[s]) maxch[s] = tx_chan_o[s];
			end
			bce_or |= bp_channel_buffer_enable_o;
			hi_and &= bp_serial_out_high_o;
			lo_and &= bp_serial_out_low_o;
		end while (frame_start_o !== 1'b1);
	endtask

	task automatic idle_outputs(input logic [15:0] oe);
		check("low out", 32'(bp_serial_out_low_o), 32'hffff);
		check("high out", 32'(bp_serial_out_high_o), 32'hffff);
		check("low oe_n", 32'(bp_serial_out_low_oe_n_o), 32'(oe));
		check("high oe_n", 32'(bp_serial_out_high_oe_n_o), 32'(oe));
		check("buffer enables", 32'(bp_channel_buffer_enable_o), 32'h0);
	endtask

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	// Pin reset acts with no clock edge, for both reset state levels
	task automatic test_reset();
		for (int b = 0; b < 2; b++) begin
			@(negedge ref_clk_i);
			cfg_i.bp_output_reset_state = b[0];
			device_reset_n_i = 1'b0;
			#1 idle_outputs(b ? 16'hffff : 16'h0000);
			repeat (32) @(negedge ref_clk_i);
			check("locked in reset", 32'(frame_locked_o), 32'h0);
			check("valid in reset", rx_valid_o, 32'h0);
			device_reset_n_i = 1'b1;
		end
		cfg_i.bp_output_reset_state = 1'b0;
		$display("test reset done");
	endtask

	// Format found only after a full detect frame
	task automatic test_lock();
		repeat (12000) @(negedge ref_clk_i);
		check("early lock", 32'(frame_locked_o), 32'h0);
		for (int i = 0; i < 30000 && frame_locked_o !== 1'b1; i++) @(negedge ref_clk_i);
		check("locked", 32'(frame_locked_o), 32'h1);
		check("gci format", 32'(gci_format_o), 32'h0);
		$display("test lock done");
	endtask

	// Mixed rates per stream; streams 0 and 5 active
	task automatic test_rates();
		measure();
		for (int s = 0; s < 32; s++) begin
			check("rx count", cnt[s], 32 << in_rate_i[s]);
			check("tx last chan", 32'(maxch[s]), (32 << out_rate_i[s]) - 1);
		end
		check("enables seen", 32'(bce_or), 32'h3);
		check("active lows", 32'(lo_and & 16'h0021), 32'h0);
		check("upper driven", 32'(hi_and), 32'h0);
		$display("test rates done");
	endtask

	// Drive enable low forces idle at once
	task automatic test_drive_off();
		@(negedge ref_clk_i);
		cfg_i.output_drive_enable = 1'b0;
		cfg_i.bp_output_reset_state = 1'b1;
		#1 idle_outputs(16'hffff);
		@(negedge ref_clk_i);
		cfg_i.bp_output_reset_state = 1'b0;
		#1 idle_outputs(16'h0000);
		@(negedge ref_clk_i);
		cfg_i.output_drive_enable = 1'b1;
		$display("test drive off done");
	endtask

	// Wide mode: 16 streams of 512 channels, upper half unused
	task automatic test_mode32();
		@(negedge ref_clk_i);
		cfg_i.mode32 = 1'b1;
		bp_channel_active_bit_i = 32'h0001_0008;
		measure();
		check("rx count 32M", cnt[0], 512);
		check("tx last 32M", 32'(maxch[0]), 511);
		check("upper rx", cnt[16], 0);
		check("upper out", 32'(hi_and), 32'hffff);
		check("enables 32M", 32'(bce_or), 32'h8);
		$display("test mode32 done");
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		n_mismatch = 0;
		compares = 0;
		reset_i = 1'b1;
		device_reset_n_i = 1'b0;
		cfg_i = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
		for (int s = 0; s < 32; s++) begin
			in_rate_i[s] = 2'(s);
			out_rate_i[s] = 2'(s + 1);
		end
		tx_data_i = '0;
		bp_channel_active_bit_i = 32'h0000_0021;
		repeat (3) @(negedge ref_clk_i);
		reset_i = 1'b0;
		// Pin held low past two master clock periods
		repeat (32) @(negedge ref_clk_i);
		device_reset_n_i = 1'b1;
		test_reset();
		test_lock();
		test_rates();
		test_drive_off();
		test_mode32();
		conclude();
	end
endmodule
